// file: verilog/cgc_pkg.sv
// Package with address map, field layout and timing constants of the colour graphics control block
package cgc_pkg;

  // ----------------------------------------------------------------
  // I/O address map
  // ----------------------------------------------------------------
  localparam int IO_ADDR_W = 10;
  localparam logic [9:0] ADDR_CRTC_INDEX_SELECT = 10'h3D4;
  localparam logic [9:0] ADDR_CRTC_DATA = 10'h3D5;
  localparam logic [9:0] ADDR_VIDEO_MODE_CONTROL = 10'h3D8;
  localparam logic [9:0] ADDR_PALETTE_BORDER_SELECT = 10'h3D9;
  localparam logic [9:0] ADDR_ADAPTER_STATUS = 10'h3DA;
  localparam logic [9:0] ADDR_PEN_LATCH_CLEAR_PORT = 10'h3DB;
  localparam logic [9:0] ADDR_PEN_LATCH_PRESET_PORT = 10'h3DC;

  // ----------------------------------------------------------------
  // Timing controller register indices
  // ----------------------------------------------------------------
  localparam int CRTC_REG_COUNT = 16;
  localparam logic [7:0] IDX_HORIZ_TOTAL_CHARS = 8'h00;
  localparam logic [7:0] IDX_HORIZ_DISPLAYED_CHARS = 8'h01;
  localparam logic [7:0] IDX_HORIZ_SYNC_POSITION = 8'h02;
  localparam logic [7:0] IDX_SYNC_PULSE_WIDTHS = 8'h03;
  localparam logic [7:0] IDX_VERT_TOTAL_ROWS = 8'h04;
  localparam logic [7:0] IDX_VERT_TOTAL_ADJUST = 8'h05;
  localparam logic [7:0] IDX_VERT_DISPLAYED_ROWS = 8'h06;
  localparam logic [7:0] IDX_VERT_SYNC_POSITION = 8'h07;
  localparam logic [7:0] IDX_INTERLACE_AND_SKEW = 8'h08;
  localparam logic [7:0] IDX_MAX_SCAN_LINE = 8'h09;
  localparam logic [7:0] IDX_CURSOR_FIRST_LINE = 8'h0A;
  localparam logic [7:0] IDX_CURSOR_LAST_LINE = 8'h0B;
  localparam logic [7:0] IDX_START_ADDR_HIGH = 8'h0C;
  localparam logic [7:0] IDX_START_ADDR_LOW = 8'h0D;
  localparam logic [7:0] IDX_CURSOR_ADDR_HIGH = 8'h0E;
  localparam logic [7:0] IDX_CURSOR_ADDR_LOW = 8'h0F;
  localparam logic [7:0] IDX_PEN_ADDR_HIGH = 8'h10;
  localparam logic [7:0] IDX_PEN_ADDR_LOW = 8'h11;

  // ----------------------------------------------------------------
  // Field layout, reset values and timing
  // ----------------------------------------------------------------
  localparam int BUF_ADDR_W = 14;
  localparam logic [1:0] CURSOR_HIDDEN_CODE = 2'h1;
  localparam int CURSOR_MODE_LSB = 5;
  localparam logic [4:0] VSYNC_LINES = 5'h10;
  localparam logic [5:0] MODE_RESET = 6'h00;
  localparam logic [5:0] COLOR_RESET = 6'h00;
  localparam logic [7:0] INDEX_RESET = 8'h00;

  typedef struct packed {
    logic blink_enable;
    logic hires_graphics;
    logic video_enable;
    logic monochrome;
    logic medres_graphics;
    logic text_80_col;
  } cgc_mode_type;

  typedef struct packed {
    logic cyan_magenta_white;
    logic intensified_set;
    logic [3:0] border_color;
  } cgc_color_type;

  typedef enum logic {FR_ROWS, FR_ADJUST} cgc_frame_type;

endpackage

// file: verilog/cgc_regs.sv
// Host registers and raster timing controller of the colour graphics adapter
//
// Behaviour
// R01 - Six-bit write-only video mode register at I/O 3D8, not readable.
// R02 - Mode bit 0: 80-column text when 1, 40-column when 0.
// R03 - Mode bit 1: 320x200 graphics when 1, text when 0.
// R04 - Mode bit 2: monochrome output when 1, colour when 0.
// R05 - Mode bit 3: video output enabled when 1, suppressed when 0.
// R06 - Mode bit 4: 640x200 graphics when 1, other modes when 0.
// R07 - Mode bit 5: attribute top bit is blink when 1, background intensity when 0.
// R08 - Six-bit write-only colour choice register at I/O 3D9.
// R09 - Colour bits 0-3: border, medium background, high-resolution foreground colour.
// R10 - Colour bit 4: intensified alternate set in graphics, else text background.
// R11 - Colour bit 5: cyan/magenta/white palette when 1, green/red/brown when 0.
// R12 - Sixteen 8-bit timing registers reached through index port 3D4.
// R13 - Host writes index to 3D4 first, then value to 3D5.
// R14 - Four-bit read-only status register at I/O 3DA.
// R15 - Status bit 0 high while controller is not fetching display buffer.
// R16 - Status bit 1 high once light pen trigger latch is set.
// R17 - Status bit 2 high while pen switch open, low when closed.
// R18 - Status bit 3 high during the whole vertical retrace.
// R19 - Any access to 3DC presets pen latch, to 3DB clears it.
// R20 - Register 0 is total characters minus one; register 1 displayed count.
// R21 - Vertical sync lasts 16 lines; horizontal sync width 1-15 from register 3.
// R22 - Registers 12/13 give start address, 14/15 cursor address, low byte second.
// R23 - Data port writes with index above 15 are ignored.
`timescale 1ns/1ps

module cgc_regs #(
  parameter int CHAR_CLK_DIV = 8
) (
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire logic [cgc_pkg::IO_ADDR_W-1:0] IO_ADDR,
  input wire logic [7:0] IO_DATA_IN,
  output logic [7:0] IO_DATA_OUT,
  output logic IO_DATA_OE,
  input wire logic IO_READ_N,
  input wire logic IO_WRITE_N,
  input wire logic IO_AEN,
  input wire logic PEN_TRIGGER,
  input wire logic PEN_SWITCH_CLOSED,
  output cgc_pkg::cgc_mode_type MODE_CTRL,
  output cgc_pkg::cgc_color_type COLOR_SEL,
  output logic HSYNC,
  output logic VSYNC,
  output logic DISPLAY_ACTIVE,
  output logic VIDEO_ON,
  output logic CURSOR_ACTIVE,
  output logic [cgc_pkg::BUF_ADDR_W-1:0] BUF_ADDR,
  output logic [4:0] SCAN_LINE
);
  import cgc_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [IO_ADDR_W-1:0] addr_s1_reg, addr_s2_reg;
  logic [7:0] data_s1_reg, data_s2_reg;
  logic rd_n_s1_reg, rd_n_s2_reg, rd_n_s3_reg;
  logic wr_n_s1_reg, wr_n_s2_reg, wr_n_s3_reg;
  logic trig_s1_reg, trig_s2_reg, trig_s3_reg;
  logic aen_s1_reg, aen_s2_reg, sw_s1_reg, sw_s2_reg;

  // Sampling through reset keeps real pin levels, so no false edge at release
  always_ff @(posedge REF_CLK) begin
    addr_s1_reg <= IO_ADDR;
    addr_s2_reg <= addr_s1_reg;
    data_s1_reg <= IO_DATA_IN;
    data_s2_reg <= data_s1_reg;
    rd_n_s1_reg <= IO_READ_N;
    rd_n_s2_reg <= rd_n_s1_reg;
    rd_n_s3_reg <= rd_n_s2_reg;
    wr_n_s1_reg <= IO_WRITE_N;
    wr_n_s2_reg <= wr_n_s1_reg;
    wr_n_s3_reg <= wr_n_s2_reg;
    aen_s1_reg <= IO_AEN;
    aen_s2_reg <= aen_s1_reg;
    trig_s1_reg <= PEN_TRIGGER;
    trig_s2_reg <= trig_s1_reg;
    trig_s3_reg <= trig_s2_reg;
    sw_s1_reg <= PEN_SWITCH_CLOSED;
    sw_s2_reg <= sw_s1_reg;
  end

  logic wr_strobe, rd_strobe, rd_active, pen_trig_rise;
  assign wr_strobe = !wr_n_s2_reg && wr_n_s3_reg && !aen_s2_reg;
  assign rd_strobe = !rd_n_s2_reg && rd_n_s3_reg && !aen_s2_reg;
  assign rd_active = !rd_n_s2_reg && !aen_s2_reg;
  assign pen_trig_rise = trig_s2_reg && !trig_s3_reg;

  // ----------------------------------------------------------------
  // Mode, colour and index registers
  // ----------------------------------------------------------------
  cgc_mode_type mode_reg;
  cgc_color_type color_reg;
  logic [7:0] index_reg;

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      mode_reg <= MODE_RESET;
      color_reg <= COLOR_RESET;
      index_reg <= INDEX_RESET;
    end else if (wr_strobe) begin
      if (addr_s2_reg == ADDR_VIDEO_MODE_CONTROL) begin
        mode_reg <= data_s2_reg[5:0]; // see R01
      end else if (addr_s2_reg == ADDR_PALETTE_BORDER_SELECT) begin
        color_reg <= data_s2_reg[5:0]; // see R08
      end else if (addr_s2_reg == ADDR_CRTC_INDEX_SELECT) begin
        index_reg <= data_s2_reg; // see R12
      end
    end
  end

  assign MODE_CTRL = mode_reg; // see R02 see R03 see R04 see R06 see R07
  assign COLOR_SEL = color_reg; // see R09 see R10 see R11

  // ----------------------------------------------------------------
  // Timing controller register file
  // ----------------------------------------------------------------
  logic [7:0] crtc_reg [CRTC_REG_COUNT];

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      for (int i = 0; i < CRTC_REG_COUNT; i++) begin
        crtc_reg[i] <= 8'h00;
      end
    end else if (wr_strobe && addr_s2_reg == ADDR_CRTC_DATA && index_reg < 8'(CRTC_REG_COUNT)) begin // see R13 see R23
      crtc_reg[index_reg[3:0]] <= data_s2_reg; // see R12
    end
  end

  logic [7:0] h_total, h_disp, h_sync_pos, v_total, v_disp, v_sync_pos;
  logic [3:0] h_sync_width;
  logic [6:0] v_adjust;
  logic [4:0] max_scan;
  logic [BUF_ADDR_W-1:0] start_addr, cursor_addr;
  assign h_total = crtc_reg[IDX_HORIZ_TOTAL_CHARS[3:0]]; // see R20
  assign h_disp = crtc_reg[IDX_HORIZ_DISPLAYED_CHARS[3:0]]; // see R20
  assign h_sync_pos = crtc_reg[IDX_HORIZ_SYNC_POSITION[3:0]];
  assign h_sync_width = crtc_reg[IDX_SYNC_PULSE_WIDTHS[3:0]][3:0]; // see R21
  assign v_total = crtc_reg[IDX_VERT_TOTAL_ROWS[3:0]];
  assign v_adjust = crtc_reg[IDX_VERT_TOTAL_ADJUST[3:0]][6:0];
  assign v_disp = crtc_reg[IDX_VERT_DISPLAYED_ROWS[3:0]];
  assign v_sync_pos = crtc_reg[IDX_VERT_SYNC_POSITION[3:0]];
  assign max_scan = crtc_reg[IDX_MAX_SCAN_LINE[3:0]][4:0];
  assign start_addr = {crtc_reg[IDX_START_ADDR_HIGH[3:0]][5:0], crtc_reg[IDX_START_ADDR_LOW[3:0]]}; // see R22
  assign cursor_addr = {crtc_reg[IDX_CURSOR_ADDR_HIGH[3:0]][5:0], crtc_reg[IDX_CURSOR_ADDR_LOW[3:0]]}; // see R22

  // ----------------------------------------------------------------
  // Character clock divider
  // ----------------------------------------------------------------
  logic [7:0] div_reg;
  logic char_tick;
  assign char_tick = (div_reg == 8'(CHAR_CLK_DIV - 1));

  always_ff @(posedge REF_CLK) begin
    if (RESET || char_tick) begin
      div_reg <= 8'h00;
    end else begin
      div_reg <= div_reg + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Horizontal counter and sync
  // ----------------------------------------------------------------
  logic [7:0] h_reg;
  logic [3:0] hs_cnt_reg;
  logic line_end;
  assign line_end = char_tick && (h_reg == h_total); // see R20

  always_ff @(posedge REF_CLK) begin
    if (RESET || line_end) begin
      h_reg <= 8'h00;
    end else if (char_tick) begin
      h_reg <= h_reg + 8'h01;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      hs_cnt_reg <= 4'h0;
    end else if (char_tick) begin
      if (h_reg == h_sync_pos) begin
        hs_cnt_reg <= h_sync_width; // see R21
      end else if (hs_cnt_reg != 4'h0) begin
        hs_cnt_reg <= hs_cnt_reg - 4'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Vertical sequencer
  // ----------------------------------------------------------------
  cgc_frame_type frame_reg;
  logic [7:0] row_reg;
  logic [6:0] scan_reg;
  logic [4:0] vs_cnt_reg;
  logic [BUF_ADDR_W-1:0] row_addr_reg;
  logic row_end, frame_end;
  assign row_end = line_end && frame_reg == FR_ROWS && scan_reg[4:0] == max_scan;
  assign frame_end = line_end && ((frame_reg == FR_ADJUST && scan_reg == v_adjust - 7'h01)
    || (row_end && row_reg == v_total && v_adjust == 7'h00));

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      frame_reg <= FR_ROWS;
      row_reg <= 8'h00;
      scan_reg <= 7'h00;
    end else if (frame_end) begin
      frame_reg <= FR_ROWS;
      row_reg <= 8'h00;
      scan_reg <= 7'h00;
    end else if (line_end) begin
      case (frame_reg)
        FR_ROWS: begin
          if (row_end) begin
            scan_reg <= 7'h00;
            if (row_reg == v_total) begin
              frame_reg <= FR_ADJUST;
            end else begin
              row_reg <= row_reg + 8'h01;
            end
          end else begin
            scan_reg <= scan_reg + 7'h01;
          end
        end
        FR_ADJUST: begin
          scan_reg <= scan_reg + 7'h01;
        end
        default: begin
          frame_reg <= FR_ROWS;
        end
      endcase
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      vs_cnt_reg <= 5'h00;
    end else if (row_end && row_reg + 8'h01 == v_sync_pos) begin
      vs_cnt_reg <= VSYNC_LINES; // see R21
    end else if (line_end && vs_cnt_reg != 5'h00) begin
      vs_cnt_reg <= vs_cnt_reg - 5'h01;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      row_addr_reg <= '0;
    end else if (frame_end) begin
      row_addr_reg <= start_addr; // see R22
    end else if (row_end) begin
      row_addr_reg <= row_addr_reg + BUF_ADDR_W'(h_disp);
    end
  end

  // ----------------------------------------------------------------
  // Raster outputs
  // ----------------------------------------------------------------
  logic disp_now;
  logic [BUF_ADDR_W-1:0] addr_now;
  logic [7:0] cur_first, cur_last;
  assign disp_now = frame_reg == FR_ROWS && h_reg < h_disp && row_reg < v_disp;
  assign addr_now = row_addr_reg + BUF_ADDR_W'(h_reg);
  assign cur_first = crtc_reg[IDX_CURSOR_FIRST_LINE[3:0]];
  assign cur_last = crtc_reg[IDX_CURSOR_LAST_LINE[3:0]];

  logic disp_reg, hsync_reg, vsync_reg, cursor_reg;
  logic [BUF_ADDR_W-1:0] buf_addr_reg;
  logic [4:0] scan_out_reg;

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      disp_reg <= 1'b0;
      hsync_reg <= 1'b0;
      vsync_reg <= 1'b0;
      cursor_reg <= 1'b0;
      buf_addr_reg <= '0;
      scan_out_reg <= 5'h00;
    end else begin
      disp_reg <= disp_now;
      hsync_reg <= hs_cnt_reg != 4'h0; // see R21
      vsync_reg <= vs_cnt_reg != 5'h00; // see R21
      cursor_reg <= disp_now && addr_now == cursor_addr
        && cur_first[CURSOR_MODE_LSB +: 2] != CURSOR_HIDDEN_CODE
        && scan_reg[4:0] >= cur_first[4:0] && scan_reg[4:0] <= cur_last[4:0];
      buf_addr_reg <= addr_now;
      scan_out_reg <= scan_reg[4:0];
    end
  end

  assign HSYNC = hsync_reg;
  assign VSYNC = vsync_reg;
  assign DISPLAY_ACTIVE = disp_reg;
  assign VIDEO_ON = disp_reg && mode_reg.video_enable; // see R05
  assign CURSOR_ACTIVE = cursor_reg;
  assign BUF_ADDR = buf_addr_reg;
  assign SCAN_LINE = scan_out_reg;

  // ----------------------------------------------------------------
  // Light pen latch and captured address
  // ----------------------------------------------------------------
  logic pen_latch_reg;
  logic [BUF_ADDR_W-1:0] pen_addr_reg;
  logic io_access;
  assign io_access = wr_strobe || rd_strobe;

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      pen_latch_reg <= 1'b0;
    end else if (pen_trig_rise || (io_access && addr_s2_reg == ADDR_PEN_LATCH_PRESET_PORT)) begin // see R19
      pen_latch_reg <= 1'b1; // see R16
    end else if (io_access && addr_s2_reg == ADDR_PEN_LATCH_CLEAR_PORT) begin
      pen_latch_reg <= 1'b0; // see R19
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      pen_addr_reg <= '0;
    end else if (pen_trig_rise && !pen_latch_reg) begin
      pen_addr_reg <= buf_addr_reg;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic [7:0] status_val;
  assign status_val = {4'h0, vsync_reg, !sw_s2_reg, pen_latch_reg, !disp_reg}; // see R14 see R15 see R16 see R17 see R18

  logic [7:0] rd_data_reg;
  logic rd_oe_reg;

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      rd_data_reg <= 8'h00;
      rd_oe_reg <= 1'b0;
    end else if (rd_active && addr_s2_reg == ADDR_ADAPTER_STATUS) begin
      rd_data_reg <= status_val; // see R14
      rd_oe_reg <= 1'b1;
    end else if (rd_active && addr_s2_reg == ADDR_CRTC_DATA) begin
      rd_oe_reg <= 1'b1;
      if (index_reg == IDX_CURSOR_ADDR_HIGH || index_reg == IDX_CURSOR_ADDR_LOW) begin
        rd_data_reg <= crtc_reg[index_reg[3:0]];
      end else if (index_reg == IDX_PEN_ADDR_HIGH) begin
        rd_data_reg <= {2'h0, pen_addr_reg[13:8]};
      end else if (index_reg == IDX_PEN_ADDR_LOW) begin
        rd_data_reg <= pen_addr_reg[7:0];
      end else begin
        rd_data_reg <= 8'h00;
      end
    end else begin
      rd_data_reg <= 8'h00;
      rd_oe_reg <= 1'b0; // see R01
    end
  end

  assign IO_DATA_OUT = rd_data_reg;
  assign IO_DATA_OE = rd_oe_reg;

endmodule // cgc_regs

// file: testbench/cgc_regs_checker.sv
// Assertion checker for the colour graphics control block
`timescale 1ns/1ps
module cgc_regs_checker (
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire logic [cgc_pkg::IO_ADDR_W-1:0] IO_ADDR,
  input wire logic [7:0] IO_DATA_IN,
  input wire logic [7:0] IO_DATA_OUT,
  input wire logic IO_DATA_OE,
  input wire logic IO_READ_N,
  input wire logic IO_WRITE_N,
  input wire logic IO_AEN,
  input wire cgc_pkg::cgc_mode_type MODE_CTRL,
  input wire cgc_pkg::cgc_color_type COLOR_SEL,
  input wire logic HSYNC,
  input wire logic VSYNC,
  input wire logic DISPLAY_ACTIVE,
  input wire logic VIDEO_ON
);
  import cgc_pkg::*;
  logic hs_d, armed, chk;
  logic [5:0] vcnt;
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RESET);
  // ------------------------------------------------
  // Line count of each sync pulse seen in full
  // ------------------------------------------------
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      hs_d <= 1'b0;
      armed <= 1'b0;
      chk <= 1'b0;
      vcnt <= 6'h00;
    end else begin
      hs_d <= HSYNC;
      if (HSYNC && !hs_d && !VSYNC) begin
        armed <= 1'b1;
      end
      if ($rose(VSYNC)) begin
        chk <= armed;
        vcnt <= 6'h00;
      end else if (HSYNC && !hs_d && VSYNC) begin
        vcnt <= vcnt + 6'h01;
      end
    end
  end
  // ------------------------------------------------
  // Properties
  // ------------------------------------------------
  property p_mode_write;
    $fell(IO_WRITE_N) && !IO_AEN && IO_ADDR == ADDR_VIDEO_MODE_CONTROL |-> ##4 MODE_CTRL == IO_DATA_IN[5:0];
  endproperty
  a_mode_write: assert property (p_mode_write) else $error("mode write lost");
  property p_color_write;
    $fell(IO_WRITE_N) && !IO_AEN && IO_ADDR == ADDR_PALETTE_BORDER_SELECT |-> ##4 COLOR_SEL == IO_DATA_IN[5:0];
  endproperty
  a_color_write: assert property (p_color_write) else $error("colour write lost");
  property p_aen_ignored;
    $fell(IO_WRITE_N) && IO_AEN |=> ($stable(MODE_CTRL) && $stable(COLOR_SEL)) [*5];
  endproperty
  a_aen_ignored: assert property (p_aen_ignored) else $error("write taken during DMA cycle");
  property p_vsync_lines;
    $fell(VSYNC) && chk |-> vcnt == 6'h10;
  endproperty
  a_vsync_lines: assert property (p_vsync_lines) else $error("vertical sync not 16 lines");
  property p_video_gate;
    VIDEO_ON == (MODE_CTRL.video_enable && DISPLAY_ACTIVE);
  endproperty
  a_video_gate: assert property (p_video_gate) else $error("video on while gated off");
  property p_oe_source;
    $rose(IO_DATA_OE) |-> !$past(IO_READ_N, 2) && (IO_ADDR == ADDR_ADAPTER_STATUS || IO_ADDR == ADDR_CRTC_DATA);
  endproperty
  a_oe_source: assert property (p_oe_source) else $error("bus driven without readable read");
  property p_oe_release;
    $rose(IO_READ_N) |-> ##[1:4] !IO_DATA_OE;
  endproperty
  a_oe_release: assert property (p_oe_release) else $error("bus not released");
  property p_status_high;
    IO_DATA_OE && IO_ADDR == ADDR_ADAPTER_STATUS |-> IO_DATA_OUT[7:4] == 4'h0;
  endproperty
  a_status_high: assert property (p_status_high) else $error("status upper bits set");
endmodule // cgc_regs_checker

bind cgc_regs cgc_regs_checker chk_i (.REF_CLK(REF_CLK), .RESET(RESET), .IO_ADDR(IO_ADDR),
  .IO_DATA_IN(IO_DATA_IN), .IO_DATA_OUT(IO_DATA_OUT), .IO_DATA_OE(IO_DATA_OE), .IO_READ_N(IO_READ_N),
  .IO_WRITE_N(IO_WRITE_N), .IO_AEN(IO_AEN), .MODE_CTRL(MODE_CTRL), .COLOR_SEL(COLOR_SEL), .HSYNC(HSYNC),
  .VSYNC(VSYNC), .DISPLAY_ACTIVE(DISPLAY_ACTIVE), .VIDEO_ON(VIDEO_ON));

// file: testbench/cgc_host_model.sv
// Host processor model driving the I/O bus of the colour graphics block
`timescale 1ns/1ps
module cgc_host_model (
  input wire logic REF_CLK,
  output logic [cgc_pkg::IO_ADDR_W-1:0] IO_ADDR,
  output logic [7:0] IO_DATA_IN,
  output logic IO_READ_N,
  output logic IO_WRITE_N,
  output logic IO_AEN,
  input wire logic [7:0] IO_DATA_OUT,
  input wire logic IO_DATA_OE
);
  import cgc_pkg::*;
  initial begin
    IO_ADDR = 10'h000;
    IO_DATA_IN = 8'h00;
    IO_READ_N = 1'b1;
    IO_WRITE_N = 1'b1;
    IO_AEN = 1'b0;
  end
  // ------------------------------------------------
  // Bus cycles
  // ------------------------------------------------
  task automatic io_wr(input logic [9:0] a, input logic [7:0] d, input logic aen);
    @(posedge REF_CLK);
    IO_ADDR <= a;
    IO_DATA_IN <= d;
    IO_AEN <= aen;
    repeat (2) @(posedge REF_CLK);
    IO_WRITE_N <= 1'b0;
    repeat (4) @(posedge REF_CLK);
    IO_WRITE_N <= 1'b1;
    repeat (3) @(posedge REF_CLK);
    IO_DATA_IN <= ~d;
    IO_AEN <= 1'b0;
  endtask
  task automatic io_rd(input logic [9:0] a, output logic [7:0] d, output logic oe);
    int n;
    d = 8'h00;
    oe = 1'b0;
    @(posedge REF_CLK);
    IO_ADDR <= a;
    repeat (2) @(posedge REF_CLK);
    IO_READ_N <= 1'b0;
    for (n = 0; n < 6 && oe !== 1'b1; n++) begin
      @(posedge REF_CLK);
      oe = IO_DATA_OE;
      d = IO_DATA_OUT;
    end
    IO_READ_N <= 1'b1;
    repeat (4) @(posedge REF_CLK);
  endtask
  // Index first, then the value through the data port
  task automatic crt_wr(input logic [7:0] idx, input logic [7:0] val);
    io_wr(ADDR_CRTC_INDEX_SELECT, idx, 1'b0);
    io_wr(ADDR_CRTC_DATA, val, 1'b0);
  endtask
endmodule // cgc_host_model

// file: testbench/color_graphics_control_regs_tb.sv
// Self-checking testbench for the colour graphics control block
`timescale 1ns/1ps
`define CHK(n, e, a) begin \
  samples_checked++; \
  if ((a) !== (e)) begin \
    fails++; \
    $display("[ERR] %s expected %0h seen %0h", n, e, a); \
  end \
end
module color_graphics_control_regs_tb;
  import cgc_pkg::*;
  localparam int DIV = 2;
  localparam logic [7:0] MODES [7] = '{8'h2C, 8'h28, 8'h2D, 8'h29, 8'h2A, 8'h2E, 8'h1E};
  localparam logic [9:0] NO_RD [6] = '{10'h3D8, 10'h3D9, 10'h3D4, 10'h3DC, 10'h3DB, 10'h3E0};
  localparam logic [7:0] T_IDX [13] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h05, 8'h06, 8'h07, 8'h09, 8'h0C, 8'h0D, 8'h03,
    8'h0E, 8'h0F};
  localparam logic [7:0] T_VAL [13] = '{8'h09, 8'h06, 8'h07, 8'h1D, 8'h00, 8'h04, 8'h05, 8'h00, 8'h01, 8'h23, 8'h02,
    8'h01, 8'h23};
  logic ref_clk, rst, pen_trig, pen_closed, io_oe, io_rd_n, io_wr_n, io_aen;
  logic hsync, vsync, disp, video, cursor;
  logic [9:0] io_addr;
  logic [7:0] io_din, io_dout;
  logic [13:0] buf_addr;
  logic [4:0] scan;
  cgc_mode_type mode;
  cgc_color_type color;
  int fails, samples_checked;
  initial ref_clk = 1'b0;
  always #4 ref_clk = ~ref_clk;
  cgc_regs #(.CHAR_CLK_DIV(DIV)) uut (.REF_CLK(ref_clk), .RESET(rst), .IO_ADDR(io_addr), .IO_DATA_IN(io_din),
    .IO_DATA_OUT(io_dout), .IO_DATA_OE(io_oe), .IO_READ_N(io_rd_n), .IO_WRITE_N(io_wr_n), .IO_AEN(io_aen),
    .PEN_TRIGGER(pen_trig), .PEN_SWITCH_CLOSED(pen_closed), .MODE_CTRL(mode), .COLOR_SEL(color), .HSYNC(hsync),
    .VSYNC(vsync), .DISPLAY_ACTIVE(disp), .VIDEO_ON(video), .CURSOR_ACTIVE(cursor), .BUF_ADDR(buf_addr),
    .SCAN_LINE(scan));
  cgc_host_model host (.REF_CLK(ref_clk), .IO_ADDR(io_addr), .IO_DATA_IN(io_din), .IO_READ_N(io_rd_n),
    .IO_WRITE_N(io_wr_n), .IO_AEN(io_aen), .IO_DATA_OUT(io_dout), .IO_DATA_OE(io_oe));
  // ------------------------------------------------
  // Helpers
  // ------------------------------------------------
  task automatic report_and_stop;
    $display("Checks made %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  function automatic logic pick(input int s);
    return (s == 0) ? hsync : (s == 1) ? disp : vsync;
  endfunction
  task automatic tick(inout int n);
    @(posedge ref_clk);
    n++;
  endtask
  task automatic meas(input int s, output int hi, output int per);
    int n;
    n = 0;
    while (pick(s) !== 1'b0 && n < 4000) tick(n);
    while (pick(s) !== 1'b1 && n < 4000) tick(n);
    per = n;
    while (pick(s) === 1'b1 && n < 4000) tick(n);
    hi = n - per;
    while (pick(s) !== 1'b1 && n < 4000) tick(n);
    per = n - per;
    if (n >= 4000) begin
      fails++;
      $display("[ERR] raster signal %0d stuck", s);
      report_and_stop();
    end
  endtask
  task automatic wait_hi(input int s);
    int n;
    n = 0;
    while (pick(s) !== 1'b1 && n < 4000) tick(n);
    if (n >= 4000) begin
      fails++;
      $display("[ERR] raster signal %0d expected 1 seen 0", s);
      report_and_stop();
    end
  endtask
  // ------------------------------------------------
  // Main sequence
  // ------------------------------------------------
  initial begin
    logic [7:0] d, v, c;
    logic oe;
    int i, hi, per;
    logic [9:0] a;
    fails = 0;
    samples_checked = 0;
    rst = 1'b1;
    pen_trig = 1'b0;
    pen_closed = 1'b0;
    void'($urandom(32'hf09b_e29c));
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (3) @(posedge ref_clk);
    host.io_rd(ADDR_ADAPTER_STATUS, d, oe);
    `CHK("status oe", 1'b1, oe)
    `CHK("status idle", 8'h05, d)
    pen_closed <= 1'b1;
    host.io_rd(ADDR_ADAPTER_STATUS, d, oe);
    `CHK("switch closed", 1'b0, d[2])
    for (i = 0; i < 6; i++) begin
      host.io_rd(NO_RD[i], d, oe);
      `CHK("write-only oe", 1'b0, oe)
    end
    for (i = 0; i < 10; i++) begin
      v = (i < 7) ? MODES[i] : 8'($urandom_range(0, 63));
      c = (i == 0) ? 8'h30 : (i == 1) ? 8'h3F : 8'($urandom_range(0, 63));
      host.io_wr(ADDR_VIDEO_MODE_CONTROL, v, 1'b0);
      host.io_wr(ADDR_PALETTE_BORDER_SELECT, c, 1'b0);
      `CHK("80 col", v[0], mode.text_80_col)
      `CHK("medres", v[1], mode.medres_graphics)
      `CHK("mono", v[2], mode.monochrome)
      `CHK("video en", v[3], mode.video_enable)
      `CHK("hires", v[4], mode.hires_graphics)
      `CHK("blink", v[5], mode.blink_enable)
      `CHK("border", c[3:0], color.border_color)
      `CHK("intense", c[4], color.intensified_set)
      `CHK("palette", c[5], color.cyan_magenta_white)
    end
    host.io_wr(ADDR_VIDEO_MODE_CONTROL, ~v, 1'b1);
    `CHK("dma write", v[5:0], 6'(mode))
    pen_trig <= 1'b1;
    repeat (4) @(posedge ref_clk);
    pen_trig <= 1'b0;
    host.io_rd(ADDR_ADAPTER_STATUS, d, oe);
    `CHK("pen trigger", 1'b1, d[1])
    for (i = 0; i < 4; i++) begin
      a = i[0] ? ADDR_PEN_LATCH_PRESET_PORT : ADDR_PEN_LATCH_CLEAR_PORT;
      if (i < 2) begin
        host.io_wr(a, 8'($urandom()), 1'b0);
      end else begin
        host.io_rd(a, d, oe);
      end
      host.io_rd(ADDR_ADAPTER_STATUS, d, oe);
      `CHK("pen latch", i[0], d[1])
    end
    v = 8'($urandom_range(1, 63));
    host.crt_wr(IDX_CURSOR_ADDR_HIGH, v);
    host.crt_wr(IDX_CURSOR_ADDR_LOW, ~v);
    host.crt_wr(8'h1E, 8'hC0);
    host.io_wr(ADDR_CRTC_INDEX_SELECT, IDX_CURSOR_ADDR_HIGH, 1'b0);
    host.io_rd(ADDR_CRTC_DATA, d, oe);
    `CHK("index above 15", v, d)
    host.io_wr(ADDR_CRTC_INDEX_SELECT, IDX_CURSOR_ADDR_LOW, 1'b0);
    host.io_rd(ADDR_CRTC_DATA, d, oe);
    `CHK("cursor low", ~v, d)
    for (i = 0; i < 13; i++) host.crt_wr(T_IDX[i], T_VAL[i]);
    host.io_wr(ADDR_VIDEO_MODE_CONTROL, 8'h29, 1'b0);
    meas(2, hi, per);
    `CHK("vsync width", 16 * 10 * DIV, hi)
    wait_hi(1);
    `CHK("start address", 14'h0123, buf_addr)
    `CHK("cursor", 1'b1, cursor)
    `CHK("video on", 1'b1, video)
    meas(1, hi, per);
    `CHK("displayed", 6 * DIV, hi)
    `CHK("line total", 10 * DIV, per)
    meas(0, hi, per);
    `CHK("hsync width", 2 * DIV, hi)
    wait_hi(2);
    repeat (20) @(posedge ref_clk);
    host.io_rd(ADDR_ADAPTER_STATUS, d, oe);
    `CHK("retrace", 1'b1, d[3])
    `CHK("no fetch", 1'b1, d[0])
    host.io_wr(ADDR_VIDEO_MODE_CONTROL, 8'h21, 1'b0);
    wait_hi(1);
    `CHK("video off", 1'b0, video)
    report_and_stop();
  end
endmodule // color_graphics_control_regs_tb
